// [rtcac_cfg.svh]
`ifndef RTCAC_CFG_SVH
`define RTCAC_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RTCAC_OFS_CTRL    7'h00
`define RTCAC_OFS_TRIM    7'h04
`define RTCAC_OFS_YEAR    7'h08
`define RTCAC_OFS_MONTH   7'h0C
`define RTCAC_OFS_DAY     7'h10
`define RTCAC_OFS_WDAY    7'h14
`define RTCAC_OFS_HOUR    7'h18
`define RTCAC_OFS_MIN     7'h1C
`define RTCAC_OFS_SEC     7'h20
`define RTCAC_OFS_ALMCTL  7'h24
`define RTCAC_OFS_ALMRPT  7'h28
`define RTCAC_OFS_ALMMON  7'h2C
`define RTCAC_OFS_ALMWD   7'h30
`define RTCAC_OFS_ALMDAY  7'h34
`define RTCAC_OFS_ALMHR   7'h38
`define RTCAC_OFS_ALMMIN  7'h3C
`define RTCAC_OFS_ALMSEC  7'h40
`define RTCAC_OFS_FLAG    7'h44

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTCAC_CTRL_RUN    7
`define RTCAC_CTRL_UNLOCK 5
`define RTCAC_CTRL_PEND   4
`define RTCAC_CTRL_HALF   3
`define RTCAC_ALM_ON      7
`define RTCAC_ALM_CHIME   6
`define RTCAC_ALM_IVL_HI  5
`define RTCAC_ALM_IVL_LO  2

// ----------------------------------------
// Reset values and repeat wrap value
// ----------------------------------------
`define RTCAC_CTRL_RST    8'h00
`define RTCAC_TRIM_RST    8'h00
`define RTCAC_ALMCTL_RST  8'h00
`define RTCAC_RPT_RST     8'h00
`define RTCAC_RPT_WRAP    8'hFF

// ----------------------------------------
// Timing counts in source cycles
// ----------------------------------------
`define RTCAC_PRE_XTAL    15'h4000
`define RTCAC_PRE_INTOSC  15'h3D09
`define RTCAC_PRE_ZC50    15'h0019
`define RTCAC_PRE_ZC60    15'h001E
`define RTCAC_PEND_OSC    15'h0020
`define RTCAC_PEND_ZC     15'h0001

`endif

// [rtcac_pkg.sv]
package rtcac_pkg;

  typedef enum logic [1:0] {
    SRC_XTAL   = 2'b00,
    SRC_INTOSC = 2'b01,
    SRC_ZC50   = 2'b10,
    SRC_ZC60   = 2'b11
  } rtcac_src_t;

  typedef enum logic [3:0] {
    IVL_HALF  = 4'b0000,
    IVL_SEC   = 4'b0001,
    IVL_SEC10 = 4'b0010,
    IVL_MIN   = 4'b0011,
    IVL_MIN10 = 4'b0100,
    IVL_HOUR  = 4'b0101,
    IVL_DAY   = 4'b0110,
    IVL_WEEK  = 4'b0111,
    IVL_MONTH = 4'b1000,
    IVL_YEAR  = 4'b1001
  } rtcac_ivl_t;

  // BCD calendar digits, two per byte
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcac_time_t;

endpackage

// [rtcac_sync.sv]
`timescale 1ns/1ps

module rtcac_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  // ----------------------------------------
  // Three stages, level follows when 2 and 3 agree
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge clk_i) begin
        if (ce_i) begin
          s1_reg  <= async_i[g];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          lvl_reg <= (s2_reg == s3_reg) ? s3_reg : lvl_reg;
        end
      end
      assign level_o[g] = lvl_reg;
    end
  endgenerate

endmodule

// [rtcac_top.sv]
`timescale 1ns/1ps
`include "rtcac_cfg.svh"

module rtcac_top
  import rtcac_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  input  wire logic        BATT_KEEP_I,
  input  wire logic        XTAL_CLK_I,
  input  wire logic        INTOSC_CLK_I,
  input  wire logic        ZC_CLK_I,
  input  wire logic [6:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic             IRQ_O,
  output logic             ALARM_PULSE_O
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic        ack_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  rd_mux;
  logic        run_reg;
  logic        unlock_reg;
  rtcac_src_t  src_reg;
  logic [7:0]  trim_reg;
  rtcac_time_t t_reg;
  rtcac_time_t t_next;
  rtcac_time_t a_reg;
  logic        alm_on_reg;
  logic        chime_reg;
  logic [3:0]  ivl_reg;
  logic [7:0]  rpt_reg;
  logic        flag_reg;
  logic        pulse_reg;
  logic        phase_reg;
  logic        pend_reg;
  logic        eval_reg;
  logic [14:0] cnt_reg;
  logic [9:0]  adj_reg;
  logic [2:0]  src_lvl;
  logic [2:0]  src_prev_reg;
  logic        hit;
  logic [7:0]  dmax;
  logic        min_wrap;

  wire por_rst = SYS_RST_I & ~BATT_KEEP_I;

  localparam logic [7:0] ctrl_rst   = `RTCAC_CTRL_RST;
  localparam logic [7:0] almctl_rst = `RTCAC_ALMCTL_RST;

  // ----------------------------------------
  // Bus slave, one wait state
  // ----------------------------------------
  wire       req   = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
  wire       wr_go = AVS_WRITE_I & ack_reg & CE_I;
  wire [7:0] wd    = AVS_WRITEDATA_I[7:0];
  wire [6:0] ad    = AVS_ADDRESS_I;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (CE_I) begin
      ack_reg   <= req;
      wait_reg  <= ~req;
      rdata_reg <= (req & AVS_READ_I) ? {24'h00_0000, rd_mux} : rdata_reg;
    end
  end

  assign AVS_WAITREQUEST_O = wait_reg;
  assign AVS_READDATA_O    = rdata_reg;

  wire w_ctrl = wr_go & (ad == `RTCAC_OFS_CTRL);
  wire w_trim = wr_go & (ad == `RTCAC_OFS_TRIM);
  wire w_alm  = wr_go & (ad == `RTCAC_OFS_ALMCTL);
  wire w_rpt  = wr_go & (ad == `RTCAC_OFS_ALMRPT);
  wire w_flag = wr_go & (ad == `RTCAC_OFS_FLAG);
  wire tw     = wr_go & unlock_reg;
  wire w_year = tw & (ad == `RTCAC_OFS_YEAR);
  wire w_mon  = tw & (ad == `RTCAC_OFS_MONTH);
  wire w_day  = tw & (ad == `RTCAC_OFS_DAY);
  wire w_wday = tw & (ad == `RTCAC_OFS_WDAY);
  wire w_hour = tw & (ad == `RTCAC_OFS_HOUR);
  wire w_min  = tw & (ad == `RTCAC_OFS_MIN);
  wire w_sec  = tw & (ad == `RTCAC_OFS_SEC);

  always_comb begin
    case (ad)
      `RTCAC_OFS_CTRL:   rd_mux = {run_reg, 1'b0, unlock_reg, pend_reg,
                                   phase_reg, 1'b0, src_reg};
      `RTCAC_OFS_TRIM:   rd_mux = trim_reg;
      `RTCAC_OFS_YEAR:   rd_mux = t_reg.year;
      `RTCAC_OFS_MONTH:  rd_mux = t_reg.mon;
      `RTCAC_OFS_DAY:    rd_mux = t_reg.day;
      `RTCAC_OFS_WDAY:   rd_mux = t_reg.wday;
      `RTCAC_OFS_HOUR:   rd_mux = t_reg.hour;
      `RTCAC_OFS_MIN:    rd_mux = t_reg.min;
      `RTCAC_OFS_SEC:    rd_mux = t_reg.sec;
      `RTCAC_OFS_ALMCTL: rd_mux = {alm_on_reg, chime_reg, ivl_reg, 2'b00};
      `RTCAC_OFS_ALMRPT: rd_mux = rpt_reg;
      `RTCAC_OFS_ALMMON: rd_mux = a_reg.mon;
      `RTCAC_OFS_ALMWD:  rd_mux = a_reg.wday;
      `RTCAC_OFS_ALMDAY: rd_mux = a_reg.day;
      `RTCAC_OFS_ALMHR:  rd_mux = a_reg.hour;
      `RTCAC_OFS_ALMMIN: rd_mux = a_reg.min;
      `RTCAC_OFS_ALMSEC: rd_mux = a_reg.sec;
      `RTCAC_OFS_FLAG:   rd_mux = {7'h00, flag_reg};
      default:           rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Control and trim
  // ----------------------------------------
  // only power-on reset, held off by battery
  always_ff @(posedge MCLK_I or posedge por_rst) begin
    if (por_rst) begin
      run_reg    <= ctrl_rst[`RTCAC_CTRL_RUN];
      unlock_reg <= ctrl_rst[`RTCAC_CTRL_UNLOCK];
      src_reg    <= SRC_XTAL;
      trim_reg   <= `RTCAC_TRIM_RST;
    end else if (CE_I) begin
      if (w_ctrl) begin
        unlock_reg <= wd[`RTCAC_CTRL_UNLOCK];
        src_reg    <= rtcac_src_t'(wd[1:0]);
      end
      if (w_ctrl & unlock_reg)
        run_reg <= wd[`RTCAC_CTRL_RUN];
      if (w_trim)
        trim_reg <= wd;
    end
  end

  // ----------------------------------------
  // Clock sources and prescaler
  // ----------------------------------------
  rtcac_sync #(.W(3)) u_sync (
    .clk_i   (MCLK_I),
    .ce_i    (CE_I),
    .async_i ({ZC_CLK_I, INTOSC_CLK_I, XTAL_CLK_I}),
    .level_o (src_lvl)
  );

  always_ff @(posedge MCLK_I) begin
    if (CE_I)
      src_prev_reg <= src_lvl;
  end

  wire [2:0] src_rise = src_lvl & ~src_prev_reg;

  wire        ptick = (src_reg == SRC_XTAL)   ? src_rise[0] :
                      (src_reg == SRC_INTOSC) ? src_rise[1] : src_rise[2];
  wire [14:0] lim   = (src_reg == SRC_XTAL)   ? `RTCAC_PRE_XTAL :
                      (src_reg == SRC_INTOSC) ? `RTCAC_PRE_INTOSC :
                      (src_reg == SRC_ZC50)   ? `RTCAC_PRE_ZC50 :
                                                `RTCAC_PRE_ZC60;
  wire [14:0] win   = src_reg[1] ? `RTCAC_PEND_ZC : `RTCAC_PEND_OSC;

  wire at_end    = cnt_reg >= lim - 15'h0001;
  wire adj_pos   = ~adj_reg[9] & (|adj_reg);
  wire adj_neg   = adj_reg[9];
  wire can_skip  = cnt_reg < lim - 15'h0002;
  wire step      = run_reg & ptick;
  wire half_tick = step & at_end & ~w_sec;

  always_ff @(posedge MCLK_I) begin
    if (CE_I) begin
      if (w_sec)
        cnt_reg <= 15'h0000;
      else if (step & at_end)
        cnt_reg <= 15'h0000;
      else if (step & adj_pos & can_skip)
        cnt_reg <= cnt_reg + 15'h0002;
      else if (step & ~adj_neg)
        cnt_reg <= cnt_reg + 15'h0001;
    end
  end

  always_ff @(posedge MCLK_I or posedge por_rst) begin
    if (por_rst)
      adj_reg <= 10'h000;
    else if (CE_I) begin
      if (min_wrap)
        adj_reg <= {trim_reg, 2'b00};
      else if (step & ~at_end & adj_pos & can_skip)
        adj_reg <= adj_reg - 10'h001;
      else if (step & ~at_end & adj_neg)
        adj_reg <= adj_reg + 10'h001;
    end
  end

  // ----------------------------------------
  // Calendar counting
  // ----------------------------------------
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] low);
    if (v >= top)
      return {1'b1, low};
    else if (v[3:0] == 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  wire leap = t_reg.year[4] ? (t_reg.year[3:0] == 4'h2 ||
                               t_reg.year[3:0] == 4'h6)
                            : (t_reg.year[3:0] == 4'h0 ||
                               t_reg.year[3:0] == 4'h4 ||
                               t_reg.year[3:0] == 4'h8);

  assign dmax = (t_reg.mon == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                (t_reg.mon == 8'h04 || t_reg.mon == 8'h06 ||
                 t_reg.mon == 8'h09 || t_reg.mon == 8'h11) ? 8'h30 : 8'h31;

  wire sec_roll = half_tick & phase_reg;

  logic [8:0] s_s, s_m, s_h, s_d, s_w, s_mo, s_y;
  always_comb begin
    t_next = t_reg;
    s_s  = bcd_step(t_reg.sec,  8'h59, 8'h00);
    s_m  = bcd_step(t_reg.min,  8'h59, 8'h00);
    s_h  = bcd_step(t_reg.hour, 8'h23, 8'h00);
    s_d  = bcd_step(t_reg.day,  dmax,  8'h01);
    s_w  = bcd_step(t_reg.wday, 8'h06, 8'h00);
    s_mo = bcd_step(t_reg.mon,  8'h12, 8'h01);
    s_y  = bcd_step(t_reg.year, 8'h99, 8'h00);
    if (sec_roll) begin
      t_next.sec = s_s[7:0];
      if (s_s[8]) begin
        t_next.min = s_m[7:0];
        if (s_m[8]) begin
          t_next.hour = s_h[7:0];
          if (s_h[8]) begin
            t_next.day  = s_d[7:0];
            t_next.wday = s_w[7:0];
            if (s_d[8]) begin
              t_next.mon = s_mo[7:0];
              if (s_mo[8])
                t_next.year = s_y[7:0];
            end
          end
        end
      end
    end
    if (w_year) t_next.year = wd;
    if (w_mon)  t_next.mon  = {3'b000, wd[4:0]};
    if (w_day)  t_next.day  = {2'b00, wd[5:0]};
    if (w_wday) t_next.wday = {5'b00000, wd[2:0]};
    if (w_hour) t_next.hour = {2'b00, wd[5:0]};
    if (w_min)  t_next.min  = {1'b0, wd[6:0]};
    if (w_sec)  t_next.sec  = {1'b0, wd[6:0]};
  end

  assign min_wrap = sec_roll & s_s[8];

  always_ff @(posedge MCLK_I or posedge por_rst) begin
    if (por_rst) begin
      t_reg     <= '0;
      phase_reg <= 1'b0;
      pend_reg  <= 1'b0;
    end else if (CE_I) begin
      t_reg <= t_next;
      if (w_sec)
        phase_reg <= 1'b0;
      else if (half_tick)
        phase_reg <= ~phase_reg;
      pend_reg <= run_reg & phase_reg & ~half_tick & ~w_sec &
                  (cnt_reg >= lim - win);
    end
  end

  // ----------------------------------------
  // Alarm match and repeat
  // ----------------------------------------
  wire whole = ~phase_reg;
  wire m_s1  = t_reg.sec[3:0] == a_reg.sec[3:0];
  wire m_s   = m_s1 & (t_reg.sec[7:4] == a_reg.sec[7:4]);
  wire m_m1  = m_s & (t_reg.min[3:0] == a_reg.min[3:0]);
  wire m_m   = m_m1 & (t_reg.min[7:4] == a_reg.min[7:4]);
  wire m_h   = m_m & (t_reg.hour == a_reg.hour);
  wire m_wd  = m_h & (t_reg.wday == a_reg.wday);
  wire m_d   = m_h & (t_reg.day == a_reg.day);
  wire m_mo  = m_d & (t_reg.mon == a_reg.mon);

  always_comb begin
    unique case (ivl_reg)
      IVL_HALF:  hit = 1'b1;
      IVL_SEC:   hit = whole;
      IVL_SEC10: hit = whole & m_s1;
      IVL_MIN:   hit = whole & m_s;
      IVL_MIN10: hit = whole & m_m1;
      IVL_HOUR:  hit = whole & m_m;
      IVL_DAY:   hit = whole & m_h;
      IVL_WEEK:  hit = whole & m_wd;
      IVL_MONTH: hit = whole & m_d;
      IVL_YEAR:  hit = whole & m_mo;
      default:   hit = 1'b0;
    endcase
  end

  wire alm_evt = eval_reg & alm_on_reg & hit;

  always_ff @(posedge MCLK_I or posedge por_rst) begin
    if (por_rst) begin
      eval_reg   <= 1'b0;
      alm_on_reg <= almctl_rst[`RTCAC_ALM_ON];
      chime_reg  <= almctl_rst[`RTCAC_ALM_CHIME];
      ivl_reg    <= IVL_HALF;
      rpt_reg    <= `RTCAC_RPT_RST;
      a_reg      <= '0;
      flag_reg   <= 1'b0;
      pulse_reg  <= 1'b0;
    end else if (CE_I) begin
      eval_reg <= half_tick;
      if (w_alm) begin
        alm_on_reg <= wd[`RTCAC_ALM_ON];
        chime_reg  <= wd[`RTCAC_ALM_CHIME];
        ivl_reg    <= wd[`RTCAC_ALM_IVL_HI:`RTCAC_ALM_IVL_LO];
      end else if (alm_evt & ~chime_reg & (rpt_reg == 8'h00))
        alm_on_reg <= 1'b0;
      if (w_rpt)
        rpt_reg <= wd;
      else if (alm_evt & (rpt_reg == 8'h00) & chime_reg)
        rpt_reg <= `RTCAC_RPT_WRAP;
      else if (alm_evt & (rpt_reg != 8'h00))
        rpt_reg <= rpt_reg - 8'h01;
      if (wr_go & (ad == `RTCAC_OFS_ALMMON))  a_reg.mon  <= {3'b000, wd[4:0]};
      if (wr_go & (ad == `RTCAC_OFS_ALMWD))   a_reg.wday <= {5'b00000, wd[2:0]};
      if (wr_go & (ad == `RTCAC_OFS_ALMDAY))  a_reg.day  <= {2'b00, wd[5:0]};
      if (wr_go & (ad == `RTCAC_OFS_ALMHR))   a_reg.hour <= {2'b00, wd[5:0]};
      if (wr_go & (ad == `RTCAC_OFS_ALMMIN))  a_reg.min  <= {1'b0, wd[6:0]};
      if (wr_go & (ad == `RTCAC_OFS_ALMSEC))  a_reg.sec  <= {1'b0, wd[6:0]};
      flag_reg <= alm_evt | (flag_reg & ~(w_flag & wd[0]));
      if (alm_evt)
        pulse_reg <= ~pulse_reg;
    end
  end

  assign IRQ_O         = flag_reg;
  assign ALARM_PULSE_O = pulse_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence tick_s;
    CE_I & half_tick;
  endsequence

  alarm_once_a: assert property (
    CE_I & alm_evt & ~chime_reg & rpt_reg == 8'h00 & ~w_alm |=> ~alm_on_reg)
    else $error("alarm enable not cleared");
  chime_keep_a: assert property (
    CE_I & alm_evt & chime_reg & ~w_alm |=> alm_on_reg)
    else $error("alarm enable lost with chime");
  rpt_dec_a: assert property (
    CE_I & alm_evt & rpt_reg != 8'h00 & ~w_rpt
      |=> rpt_reg == $past(rpt_reg) - 8'h01)
    else $error("repeat count not decremented");
  rpt_wrap_a: assert property (
    CE_I & alm_evt & chime_reg & rpt_reg == 8'h00 & ~w_rpt
      |=> rpt_reg == 8'hFF)
    else $error("repeat count did not wrap");
  flag_irq_a: assert property (
    CE_I & alm_evt |=> flag_reg & IRQ_O)
    else $error("alarm flag not set");
  pulse_tog_a: assert property (
    CE_I & alm_evt |=> ALARM_PULSE_O != $past(ALARM_PULSE_O))
    else $error("alarm pulse did not toggle");
  run_lock_a: assert property (
    CE_I & w_ctrl & ~unlock_reg |=> $stable(run_reg))
    else $error("run bit written while locked");
  half_clr_a: assert property (
    CE_I & w_sec |=> ~phase_reg ##0 cnt_reg == 15'h0000)
    else $error("seconds write did not clear phase");
  tick_eval_a: assert property (
    tick_s ##1 (CE_I & ~half_tick) |-> eval_reg ##1 ~eval_reg)
    else $error("alarm evaluation not once per tick");

endmodule

// [rtcac_tb.sv]
`timescale 1ns/1ps
`include "rtcac_cfg.svh"

module testbench
  import rtcac_pkg::*;
;
  logic        mclk;
  logic        rst;
  wire         src_clk;
  logic [3:0]  src_div = 4'h0;
  logic        ce;
  logic        batt;
  logic        rd;
  logic        wr;
  logic [6:0]  addr;
  logic [31:0] wdata;
  wire  [31:0] rdata;
  wire         waitreq;
  wire         irq;
  wire         pulse;
  logic        pulse_q = 1'b0;
  logic [7:0]  q;
  int          err_count;
  int          n_checks;
  int          alarm_cnt = 0;
  int          base;
  int          gap = 0;
  int          stamp = 0;
  int          cyc = 0;

  rtcac_top dut (.MCLK_I(mclk), .SYS_RST_I(rst), .CE_I(ce),
    .BATT_KEEP_I(batt), .XTAL_CLK_I(src_clk), .INTOSC_CLK_I(src_clk),
    .ZC_CLK_I(src_clk), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .IRQ_O(irq), .ALARM_PULSE_O(pulse));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Mains source, one period per 16 system clocks
  always @(posedge mclk) src_div <= src_div + 4'h1;
  assign src_clk = src_div[3];

  // Each toggle of the pulse output is one alarm event
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (pulse !== pulse_q) begin
      alarm_cnt <= alarm_cnt + 1;
      gap       <= cyc - stamp;
      stamp     <= cyc;
    end
    pulse_q <= pulse;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_count++;
    $display("ERROR t=%0t wait limit reached", $time);
    stop_test();
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge mclk);
    addr  <= a;
    wdata <= {24'h000000, d};
    wr    <= w;
    rd    <= ~w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    r = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (waitreq !== 1'b0) timed_out();
  endtask

  task automatic w8(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic r8(input logic [6:0] a);
    bus(1'b0, a, 8'h00, q);
  endtask

  task automatic wait_alarms(input int target);
    int n;
    n = 0;
    while (alarm_cnt < target && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 4000) timed_out();
  endtask

  task automatic poll_ctrl(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      r8(`RTCAC_OFS_CTRL);
      n++;
    end while ((q & m) !== v && n < 400);
    if ((q & m) !== v) timed_out();
  endtask

  task automatic pulse_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    r8(`RTCAC_OFS_CTRL);   chk(q, `RTCAC_CTRL_RST);
    r8(`RTCAC_OFS_TRIM);   chk(q, `RTCAC_TRIM_RST);
    r8(`RTCAC_OFS_ALMCTL); chk(q, `RTCAC_ALMCTL_RST);
    r8(`RTCAC_OFS_ALMRPT); chk(q, `RTCAC_RPT_RST);
    r8(7'h7C);             chk(q, 8'h00);
    chk({6'h00, irq, pulse}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_lock();
    w8(`RTCAC_OFS_CTRL, {6'h28, SRC_ZC50});
    r8(`RTCAC_OFS_CTRL); chk(q & 8'hE7, 8'h22);
    w8(`RTCAC_OFS_CTRL, {6'h28, SRC_ZC50});
    r8(`RTCAC_OFS_CTRL); chk(q & 8'hE7, 8'hA2);
    w8(`RTCAC_OFS_YEAR, 8'h24);
    r8(`RTCAC_OFS_YEAR); chk(q, 8'h24);
    w8(`RTCAC_OFS_CTRL, 8'h82);
    w8(`RTCAC_OFS_YEAR, 8'h99);
    r8(`RTCAC_OFS_YEAR); chk(q, 8'h24);
    w8(`RTCAC_OFS_CTRL, 8'hA2);
    w8(`RTCAC_OFS_SEC, 8'h00);
    r8(`RTCAC_OFS_CTRL); chk(q & 8'h18, 8'h00);
    poll_ctrl(8'h10, 8'h10);
    chk(q & 8'h18, 8'h18);
    poll_ctrl(8'h10, 8'h00);
    chk(q & 8'h18, 8'h00);
    r8(`RTCAC_OFS_SEC);  chk(q, 8'h01);
    $display("test lock done");
  endtask

  task automatic t_repeat();
    base = alarm_cnt;
    poll_ctrl(8'h10, 8'h00);
    w8(`RTCAC_OFS_ALMRPT, 8'h01);
    w8(`RTCAC_OFS_ALMCTL, 8'h80);
    wait_alarms(base + 2);
    chk(8'(gap / 16), 8'h19);
    chk(8'(gap % 16), 8'h00);
    repeat (1400) @(posedge mclk);
    chk(8'(alarm_cnt - base), 8'h02);
    r8(`RTCAC_OFS_ALMCTL); chk(q, 8'h00);
    r8(`RTCAC_OFS_ALMRPT); chk(q, 8'h00);
    chk({7'h00, irq}, 8'h01);
    r8(`RTCAC_OFS_FLAG);   chk(q, 8'h01);
    w8(`RTCAC_OFS_FLAG, 8'h01);
    r8(`RTCAC_OFS_FLAG);   chk(q, 8'h00);
    chk({7'h00, irq}, 8'h00);
    base = alarm_cnt;
    w8(`RTCAC_OFS_ALMCTL, 8'h80);
    repeat (1400) @(posedge mclk);
    chk(8'(alarm_cnt - base), 8'h01);
    r8(`RTCAC_OFS_ALMCTL); chk(q, 8'h00);
    $display("test repeat done");
  endtask

  task automatic t_chime();
    base = alarm_cnt;
    poll_ctrl(8'h10, 8'h00);
    w8(`RTCAC_OFS_ALMRPT, 8'hFF);
    w8(`RTCAC_OFS_ALMCTL, 8'hC0);
    wait_alarms(base + 1);
    r8(`RTCAC_OFS_ALMRPT); chk(q, 8'hFE);
    poll_ctrl(8'h10, 8'h00);
    w8(`RTCAC_OFS_ALMRPT, 8'h00);
    wait_alarms(base + 2);
    r8(`RTCAC_OFS_ALMRPT); chk(q, `RTCAC_RPT_WRAP);
    r8(`RTCAC_OFS_ALMCTL); chk(q, 8'hC0);
    w8(`RTCAC_OFS_ALMCTL, 8'h00);
    $display("test chime done");
  endtask

  task automatic t_reserved();
    w8(`RTCAC_OFS_ALMCTL, 8'hA8);
    base = alarm_cnt;
    repeat (1400) @(posedge mclk);
    chk(8'(alarm_cnt - base), 8'h00);
    r8(`RTCAC_OFS_ALMCTL); chk(q, 8'hA8);
    w8(`RTCAC_OFS_ALMCTL, 8'h00);
    $display("test reserved done");
  endtask

  task automatic t_freeze();
    poll_ctrl(8'h10, 8'h00);
    w8(`RTCAC_OFS_ALMRPT, 8'h02);
    w8(`RTCAC_OFS_CTRL, 8'hA3);
    base = alarm_cnt;
    w8(`RTCAC_OFS_ALMCTL, 8'h80);
    wait_alarms(base + 2);
    chk(8'(gap / 16), 8'h1E);
    chk(8'(gap % 16), 8'h00);
    ce <= 1'b0;
    repeat (1400) @(posedge mclk);
    chk(8'(alarm_cnt - base), 8'h02);
    ce <= 1'b1;
    wait_alarms(base + 3);
    repeat (1400) @(posedge mclk);
    chk(8'(alarm_cnt - base), 8'h03);
    r8(`RTCAC_OFS_ALMCTL); chk(q, 8'h00);
    w8(`RTCAC_OFS_CTRL, 8'hA2);
    $display("test freeze done");
  endtask

  task automatic t_battery();
    w8(`RTCAC_OFS_TRIM, 8'h81);
    batt <= 1'b1;
    pulse_reset();
    r8(`RTCAC_OFS_CTRL); chk(q & 8'hE7, 8'hA2);
    r8(`RTCAC_OFS_TRIM); chk(q, 8'h81);
    batt <= 1'b0;
    pulse_reset();
    r8(`RTCAC_OFS_CTRL); chk(q, `RTCAC_CTRL_RST);
    r8(`RTCAC_OFS_TRIM); chk(q, `RTCAC_TRIM_RST);
    $display("test battery done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst       = 1'b1;
    batt      = 1'b0;
    rd        = 1'b0;
    wr        = 1'b0;
    addr      = 7'h00;
    wdata     = 32'h00000000;
    ce        = 1'b1;
    err_count = 0;
    n_checks  = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_repeat();
    t_chime();
    t_reserved();
    t_freeze();
    t_battery();
    stop_test();
  end
endmodule
